// ---- hw/sltc_pkg.sv ----
/*
  Shared constants and types of the sensor line transceiver control block:
  register offsets, reset values, timing figures, current-limit table,
  carrier structs and the driver fault state encoding.
  Assumes a single 25 MHz system clock and an APB master on the logic side.
*/
package sltc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned SLTC_CLK_HZ = 25_000_000;
  localparam int unsigned BLANK_TIME_US = 500;
  localparam int unsigned RETRY_TIME_MS = 50;
  localparam int unsigned WAKE_LOW_TIME_US = 200;
  localparam int unsigned WAKE_HOLD_TIME_US = 500;
  localparam int unsigned CNT_W = 21;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_LIMIT = 12'h008;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // load current limit in mA, indexed by {curr_sel1, curr_sel0}
  localparam logic [8:0] LIMIT_MA_LL = 9'h07D;
  localparam logic [8:0] LIMIT_MA_LH = 9'h0FC;
  localparam logic [8:0] LIMIT_MA_HL = 9'h13C;
  localparam logic [8:0] LIMIT_MA_HH = 9'h17C;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic retry_select;
    logic aux_out_level;
    logic aux_out_enable;
    logic link_drive_enable;
    logic link_xcvr_enable;
  } sltc_ctrl_s;

  typedef struct packed {
    logic uv_below;
    logic uv_release;
    logic warn_below;
    logic wake_seen;
    logic link_oc;
    logic link_th;
    logic aux_oc;
    logic aux_th;
  } sltc_sense_s;

  typedef struct packed {
    sltc_sense_s sense;
    logic tx_data;
    logic link_line;
    logic aux_in;
    logic [1:0] curr_sel;
  } sltc_in_s;

  typedef struct packed {
    logic [1:0] curr_sel;
    logic aux_drv_on;
    logic link_drv_on;
    logic rx_level;
    logic aux_in_level;
    logic warn;
    logic uvlo;
    logic aux_fault;
    logic link_fault;
  } sltc_status_s;

  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_BLANK = 2'b01,
    FS_FLAG = 2'b10,
    FS_COOL = 2'b11
  } sltc_fault_e;

endpackage : sltc_pkg

// ---- hw/sltc_top.sv ----
/*
  Control logic of the sensor line transceiver: link line and auxiliary
  push-pull drivers, auxiliary input receiver, wake-up pulse, driver fault
  handling with blanking and autoretry, current-limit select decode and
  supply warning / undervoltage flags, with APB control and status.
  Assumes analog comparators deliver overcurrent, thermal, supply and wake
  indications as asynchronous levels, and that pad logic resolves the
  three-signal pins into wires.
*/
// Decided for this implementation: the APB interface to the registers and the address map.
// Overview of operation
// RQ1: retry_select high enables autoretry overload cycling
// RQ2: drive link only with both enables high
// RQ3: link line carries inverted transmit data
// RQ4: link high impedance whenever transceiver disabled
// RQ5: aux output driven only while enabled
// RQ6: aux output carries inverted aux_out_level
// RQ7: aux_in_level is inverted aux input pin
// RQ8: aux input receiver always active
// RQ9: valid wake-up gives 200 us low pulse
// RQ10: undervoltage flag below 7.2 V, release above 7.8 V
// RQ11: warning flag while supply below 16.5 V
// RQ12: static current select sets shared limit
// RQ13: aux fault on long overcurrent or thermal
// RQ14: both drivers push-pull, logic emulates switches
// RQ15: decode select into 125/252/316/380 mA
// RQ16: retry: disable after blanking, re-enable after 50 ms
// RQ17: link fault on long overcurrent or thermal
// RQ18: receive output inverts line, low when disabled
// RQ19: synchronise pins, scale times by clock
// RQ20: analog sense indications arrive as inputs
`timescale 1ns/10ps
`default_nettype none

module sltc_top
  import sltc_pkg::*;
#(
  parameter int unsigned CLK_FREQ_HZ = sltc_pkg::SLTC_CLK_HZ,
  parameter int unsigned BLANK_CYC = sltc_pkg::BLANK_TIME_US * (CLK_FREQ_HZ / 1000) / 1000,
  parameter int unsigned RETRY_CYC = sltc_pkg::RETRY_TIME_MS * (CLK_FREQ_HZ / 1000),
  parameter int unsigned WAKE_CYC = sltc_pkg::WAKE_LOW_TIME_US * (CLK_FREQ_HZ / 1000) / 1000,
  parameter int unsigned HOLD_CYC = sltc_pkg::WAKE_HOLD_TIME_US * (CLK_FREQ_HZ / 1000) / 1000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_data,
  output logic rx_data,
  input wire logic link_line_i,
  output logic link_line_o,
  output logic link_line_oe_n,
  output logic aux_out_o,
  output logic aux_out_oe_n,
  input wire logic aux_in_pin,
  output logic aux_in_level,
  output logic wake_pulse_n,
  input wire logic curr_sel1,
  input wire logic curr_sel0,
  output logic [1:0] limit_code,
  output logic [8:0] limit_ma,
  output logic supply_uvlo_n_o,
  output logic supply_uvlo_n_oe_n,
  output logic supply_warn_n_o,
  output logic supply_warn_n_oe_n,
  output logic link_fault_n_o,
  output logic link_fault_n_oe_n,
  output logic aux_fault_n_o,
  output logic aux_fault_n_oe_n,
  input wire sltc_pkg::sltc_sense_s analog_sense
);
  import sltc_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  sltc_in_s raw;
  sltc_in_s meta_q;
  sltc_in_s sync_q;

  assign raw = '{sense: analog_sense, tx_data: tx_data, link_line: link_line_i,
                 aux_in: aux_in_pin, curr_sel: {curr_sel1, curr_sel0}};

  // every pin and comparator level crosses two flops before use
  always_ff @(posedge clk) begin
    meta_q <= raw;   // RQ19 RQ20
    sync_q <= meta_q;
  end

  // ----------------------------------------------------------------
  // registers and APB slave
  // ----------------------------------------------------------------
  sltc_ctrl_s ctrl_q;
  sltc_status_s status;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [8:0] limit_ma_q;
  logic [1:0] limit_code_q;
  logic uvlo_q;
  logic warn_q;
  logic [1:0] fault_q;
  logic [1:0] off_q;
  logic link_oe_n_q;
  logic aux_oe_n_q;
  logic rx_q;
  logic aux_in_level_q;
  logic mapped;
  logic apb_done;

  assign mapped = paddr == ADDR_CTRL || paddr == ADDR_STATUS || paddr == ADDR_LIMIT;
  // one wait state: pready rises in the second access cycle
  assign apb_done = psel && penable && pready_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_done && pwrite && paddr == ADDR_CTRL) begin
      ctrl_q <= pwdata[4:0];
    end
  end

  assign status = '{curr_sel: limit_code_q, aux_drv_on: !aux_oe_n_q,
                    link_drv_on: !link_oe_n_q, rx_level: rx_q,
                    aux_in_level: aux_in_level_q, warn: warn_q, uvlo: uvlo_q,
                    aux_fault: fault_q[1], link_fault: fault_q[0]};

  always_ff @(posedge clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      prdata_q <= 32'h0000_0000;
      if (psel && penable && !pready_q && !pwrite) begin
        unique case (paddr)
          ADDR_CTRL: prdata_q <= {27'h000_0000, ctrl_q};
          ADDR_STATUS: prdata_q <= {22'h00_0000, status};
          ADDR_LIMIT: prdata_q <= {23'h00_0000, limit_ma_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // current limit select
  // ----------------------------------------------------------------
  // the select pins are meant to be strapped; a change is simply followed
  always_ff @(posedge clk) begin
    if (reset) begin
      limit_code_q <= 2'h0;
      limit_ma_q <= LIMIT_MA_LL;
    end else begin
      limit_code_q <= sync_q.curr_sel;   // RQ12
      unique case (sync_q.curr_sel)   // RQ15
        2'b00: limit_ma_q <= LIMIT_MA_LL;
        2'b01: limit_ma_q <= LIMIT_MA_LH;
        2'b10: limit_ma_q <= LIMIT_MA_HL;
        2'b11: limit_ma_q <= LIMIT_MA_HH;
      endcase
    end
  end

  AST_LIMIT_DECODE: assert property (  // RQ15
    ##1 (limit_ma_q == ($past(sync_q.curr_sel) == 2'b00 ? LIMIT_MA_LL :
                        $past(sync_q.curr_sel) == 2'b01 ? LIMIT_MA_LH :
                        $past(sync_q.curr_sel) == 2'b10 ? LIMIT_MA_HL : LIMIT_MA_HH)))
    else $error("current limit does not match select code");

  // ----------------------------------------------------------------
  // supply monitors
  // ----------------------------------------------------------------
  // hysteresis comes from the two comparators; between them the flag holds
  always_ff @(posedge clk) begin
    if (reset) begin
      uvlo_q <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      if (sync_q.sense.uv_below) begin
        uvlo_q <= 1'b1;   // RQ10
      end else if (sync_q.sense.uv_release) begin
        uvlo_q <= 1'b0;   // RQ10
      end
      warn_q <= sync_q.sense.warn_below;   // RQ11
    end
  end

  sequence s_uv_hold;
    !sync_q.sense.uv_release;
  endsequence

  AST_UVLO_HOLD: assert property (  // RQ10
    (uvlo_q && !sync_q.sense.uv_below) and s_uv_hold |=> uvlo_q)
    else $error("undervoltage flag released before supply recovered");

  AST_WARN_TRACK: assert property (  // RQ11
    ##2 supply_warn_n_oe_n == !$past(sync_q.sense.warn_below, 2))
    else $error("warning flag does not follow the supply comparator");

  // ----------------------------------------------------------------
  // driver fault handling, 0 = link driver, 1 = aux driver
  // ----------------------------------------------------------------
  logic [1:0] oc;
  logic [1:0] th;
  sltc_fault_e fst_q [2];
  logic [CNT_W-1:0] fcnt_q [2];

  assign oc = {sync_q.sense.aux_oc, sync_q.sense.link_oc};
  assign th = {sync_q.sense.aux_th, sync_q.sense.link_th};

  for (genvar i = 0; i < 2; i++) begin : g_drv
    always_ff @(posedge clk) begin
      if (reset) begin
        fst_q[i] <= FS_IDLE;
        fcnt_q[i] <= '0;
      end else begin
        unique case (fst_q[i])
          FS_IDLE: begin
            fcnt_q[i] <= '0;
            if (oc[i]) begin
              fst_q[i] <= FS_BLANK;
            end
          end
          FS_BLANK: begin
            fcnt_q[i] <= fcnt_q[i] + 1'b1;
            if (!oc[i]) begin
              fst_q[i] <= FS_IDLE;
            end else if (fcnt_q[i] == CNT_W'(BLANK_CYC - 1)) begin
              fcnt_q[i] <= '0;
              fst_q[i] <= ctrl_q.retry_select ? FS_COOL : FS_FLAG;   // RQ1 RQ16
            end
          end
          FS_FLAG: begin
            // without retry the driver keeps limiting and only flags
            if (!oc[i]) begin
              fst_q[i] <= FS_IDLE;
            end else if (ctrl_q.retry_select) begin
              fst_q[i] <= FS_COOL;   // RQ1
            end
          end
          FS_COOL: begin
            fcnt_q[i] <= fcnt_q[i] + 1'b1;
            if (fcnt_q[i] == CNT_W'(RETRY_CYC - 1)) begin
              fcnt_q[i] <= '0;
              fst_q[i] <= FS_IDLE;   // RQ16
            end
          end
        endcase
      end
    end

    // flag stays through a retry attempt so a persisting overload never blinks
    always_ff @(posedge clk) begin
      if (reset) begin
        fault_q[i] <= 1'b0;
        off_q[i] <= 1'b0;
      end else begin
        off_q[i] <= th[i] || fst_q[i] == FS_COOL;   // RQ16
        if (th[i] || (fst_q[i] == FS_BLANK && oc[i] && fcnt_q[i] == CNT_W'(BLANK_CYC - 1))) begin
          fault_q[i] <= 1'b1;   // RQ13 RQ17
        end else if (!oc[i] && fst_q[i] != FS_COOL) begin
          fault_q[i] <= 1'b0;
        end
      end
    end

    AST_NO_RETRY: assert property (  // RQ1
      $rose(fst_q[i] == FS_COOL) |-> $past(ctrl_q.retry_select))
      else $error("driver entered retry wait with autoretry off");

    AST_FAULT_CAUSE: assert property (  // RQ13 RQ17
      $rose(fault_q[i]) |-> $past(th[i]) || ($past(oc[i]) && $past(fst_q[i] == FS_BLANK)))
      else $error("fault flag raised without overcurrent or thermal cause");
  end

  assign link_fault_n_o = 1'b0;
  assign aux_fault_n_o = 1'b0;
  assign supply_uvlo_n_o = 1'b0;
  assign supply_warn_n_o = 1'b0;

  logic lf_oe_n_q;
  logic af_oe_n_q;
  logic uv_oe_n_q;
  logic wn_oe_n_q;

  // open-drain flags: enable low pulls the pin low
  always_ff @(posedge clk) begin
    if (reset) begin
      lf_oe_n_q <= 1'b1;
      af_oe_n_q <= 1'b1;
      uv_oe_n_q <= 1'b1;
      wn_oe_n_q <= 1'b1;
    end else begin
      lf_oe_n_q <= !fault_q[0];   // RQ17
      af_oe_n_q <= !fault_q[1];   // RQ13
      uv_oe_n_q <= !uvlo_q;   // RQ10
      wn_oe_n_q <= !warn_q;   // RQ11
    end
  end

  assign link_fault_n_oe_n = lf_oe_n_q;
  assign aux_fault_n_oe_n = af_oe_n_q;
  assign supply_uvlo_n_oe_n = uv_oe_n_q;
  assign supply_warn_n_oe_n = wn_oe_n_q;

  // ----------------------------------------------------------------
  // drivers and receivers
  // ----------------------------------------------------------------
  logic link_o_q;
  logic aux_o_q;

  // both drivers are push-pull; the output enables emulate switches
  always_ff @(posedge clk) begin
    if (reset) begin
      link_oe_n_q <= 1'b1;
      link_o_q <= 1'b0;
      aux_oe_n_q <= 1'b1;
      aux_o_q <= 1'b0;
      rx_q <= 1'b0;
      aux_in_level_q <= 1'b0;
    end else begin
      link_oe_n_q <= !(ctrl_q.link_xcvr_enable && ctrl_q.link_drive_enable
                       && !off_q[0] && !uvlo_q);   // RQ2 RQ4 RQ14
      link_o_q <= !sync_q.tx_data;   // RQ3
      aux_oe_n_q <= !(ctrl_q.aux_out_enable && !off_q[1] && !uvlo_q);   // RQ5 RQ14
      aux_o_q <= !ctrl_q.aux_out_level;   // RQ6
      rx_q <= ctrl_q.link_xcvr_enable && !uvlo_q && !sync_q.link_line;   // RQ18
      aux_in_level_q <= !sync_q.aux_in;   // RQ7 RQ8
    end
  end

  assign link_line_oe_n = link_oe_n_q;
  assign link_line_o = link_o_q;
  assign aux_out_oe_n = aux_oe_n_q;
  assign aux_out_o = aux_o_q;
  assign rx_data = rx_q;
  assign aux_in_level = aux_in_level_q;

  AST_LINK_ENABLES: assert property (  // RQ2
    !link_line_oe_n |-> $past(ctrl_q.link_xcvr_enable && ctrl_q.link_drive_enable))
    else $error("link driven without both enables");

  AST_LINK_HIZ: assert property (  // RQ4
    !ctrl_q.link_xcvr_enable |=> link_line_oe_n)
    else $error("link line driven while transceiver disabled");

  AST_LINK_DATA: assert property (  // RQ3
    ##1 !link_line_oe_n |-> link_line_o == !$past(sync_q.tx_data))
    else $error("link line not the inverse of transmit data");

  AST_AUX_HIZ: assert property (  // RQ5
    !ctrl_q.aux_out_enable |=> aux_out_oe_n)
    else $error("aux output driven while disabled");

  AST_AUX_DATA: assert property (  // RQ6
    ##1 !aux_out_oe_n |-> aux_out_o != $past(ctrl_q.aux_out_level))
    else $error("aux output not the inverse of its level input");

  // the first cycle after reset still shows the cleared output, not the pin
  AST_AUX_IN: assert property (  // RQ7 RQ8
    ##1 !$past(reset) |-> aux_in_level == !$past(sync_q.aux_in))
    else $error("aux input level not the inverse of the pin");

  AST_RX_OFF: assert property (  // RQ18
    !ctrl_q.link_xcvr_enable |=> !rx_data)
    else $error("receive output not forced low while disabled");

  // ----------------------------------------------------------------
  // wake-up pulse
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] wake_cnt_q;
  logic [CNT_W-1:0] hold_cnt_q;
  logic wake_prev_q;
  logic wake_n_q;
  logic drv_prev_q;
  logic wake_start;

  // a request seen right after our own driver switched is its echo, not a wake
  assign wake_start = sync_q.sense.wake_seen && !wake_prev_q && hold_cnt_q == '0
                      && wake_cnt_q == '0;

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_cnt_q <= '0;
      drv_prev_q <= 1'b0;
    end else begin
      drv_prev_q <= !link_oe_n_q && link_o_q;
      if ((!link_oe_n_q && link_o_q) != drv_prev_q) begin
        hold_cnt_q <= CNT_W'(HOLD_CYC);
      end else if (hold_cnt_q != '0) begin
        hold_cnt_q <= hold_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wake_prev_q <= 1'b0;
      wake_cnt_q <= '0;
      wake_n_q <= 1'b1;
    end else begin
      wake_prev_q <= sync_q.sense.wake_seen;
      if (wake_start) begin
        wake_cnt_q <= CNT_W'(WAKE_CYC);
        wake_n_q <= 1'b0;   // RQ9
      end else if (wake_cnt_q != '0) begin
        wake_cnt_q <= wake_cnt_q - 1'b1;
        wake_n_q <= wake_cnt_q == CNT_W'(1);
      end
    end
  end

  assign wake_pulse_n = wake_n_q;

  sequence s_wake_req;
    wake_start;
  endsequence

  sequence s_wake_low;
    !wake_pulse_n [*2];
  endsequence

  AST_WAKE_PULSE: assert property (  // RQ9
    s_wake_req |=> s_wake_low)
    else $error("wake request did not start a low pulse");

  AST_WAKE_END: assert property (  // RQ9
    wake_cnt_q == CNT_W'(1) |=> wake_pulse_n && wake_cnt_q == '0)
    else $error("wake pulse did not end after its length");

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign limit_code = limit_code_q;
  assign limit_ma = limit_ma_q;

endmodule : sltc_top

`default_nettype wire

// ---- dv/sltc_line_master.sv ----
/*
  Model of the sensor-link master port on the far side of the link line.
  Assumes the bench sets the level that the master holds on the line
  while the block does not drive it.
*/
`timescale 1ns/10ps
`default_nettype none

module sltc_line_master (
  input wire logic drv_oe_n,
  input wire logic drv_val,
  input wire logic master_level,
  output logic line
);
  // ----------------------------------------------------------------
  // line resolution
  // ----------------------------------------------------------------
  // the block's push-pull driver wins; otherwise the master's load sets it
  assign line = (drv_oe_n == 1'b0) ? drv_val : master_level;
endmodule : sltc_line_master

`default_nettype wire

// ---- dv/tb.sv ----
/*
  Self-checking bench of the transceiver control block.
  Assumes short timing parameters and an APB slave answering in two
  access cycles; the far side of the link line is a separate model.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import sltc_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int RETRY = 40;
  logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, er, tx_data = 1'b0, rx_data, line, mlev = 1'b0;
  logic link_o, link_oe_n, aux_o, aux_oe_n, aux_in_pin = 1'b0, aux_in_level;
  logic wake_n, cs1 = 1'b0, cs0 = 1'b0, uv_o, uv_oe_n, wr_o, wr_oe_n;
  logic lf_o, lf_oe_n, af_o, af_oe_n;
  logic [1:0] limit_code;
  logic [8:0] limit_ma;
  sltc_sense_s sense = 8'h40;
  int err_count = 0, checked = 0, n;
  typedef struct packed {
    logic [4:0] ctrl;
    logic tx, ain, ml, loe, lo, aoe, ao, ail, rx;
  } sltc_row_s;
  sltc_row_s rows [9];
  logic [8:0] lim [4];

  always #20 clk = ~clk;

  sltc_top #(.BLANK_CYC(20), .RETRY_CYC(RETRY), .WAKE_CYC(10), .HOLD_CYC(0)) DUT (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_data(tx_data), .rx_data(rx_data), .link_line_i(line), .link_line_o(link_o),
    .link_line_oe_n(link_oe_n), .aux_out_o(aux_o), .aux_out_oe_n(aux_oe_n),
    .aux_in_pin(aux_in_pin), .aux_in_level(aux_in_level), .wake_pulse_n(wake_n),
    .curr_sel1(cs1), .curr_sel0(cs0), .limit_code(limit_code), .limit_ma(limit_ma),
    .supply_uvlo_n_o(uv_o), .supply_uvlo_n_oe_n(uv_oe_n), .supply_warn_n_o(wr_o),
    .supply_warn_n_oe_n(wr_oe_n), .link_fault_n_o(lf_o), .link_fault_n_oe_n(lf_oe_n),
    .aux_fault_n_o(af_o), .aux_fault_n_oe_n(af_oe_n), .analog_sense(sense));

  sltc_line_master u_master (.drv_oe_n(link_oe_n), .drv_val(link_o),
    .master_level(mlev), .line(line));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // pready is looked at on the rising edge; the request is held through that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk("apb_timeout", 32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // inputs pass two sync flops, twice for tx_data looped back through the line, and up to two register stages; outputs are
  // read at the edge after, where they still show the settled value
  task automatic settle();
    repeat (7) @(posedge clk);
  endtask : settle

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    #(40 * 20000);
    err_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    // ctrl, then tx ain mlev | link_oe_n link_o aux_oe_n aux_o aux_lvl rx
    rows[0] = {5'h00, 9'b000_1_0_1_0_1_0};
    rows[1] = {5'h02, 9'b111_1_0_1_0_0_0};
    rows[2] = {5'h01, 9'b001_1_0_1_0_1_0};
    rows[3] = {5'h01, 9'b010_1_0_1_0_0_1};
    rows[4] = {5'h03, 9'b000_0_1_1_0_1_0};
    rows[5] = {5'h03, 9'b101_0_0_1_0_1_1};
    rows[6] = {5'h04, 9'b000_1_0_0_1_1_0};
    rows[7] = {5'h0C, 9'b000_1_0_0_0_1_0};
    rows[8] = {5'h08, 9'b000_1_0_1_0_1_0};
    lim = '{9'h07D, 9'h0FC, 9'h13C, 9'h17C};
    repeat (3) @(posedge clk);
    chk("rst_link_oe_n", link_oe_n, 1'b1);
    chk("rst_aux_oe_n", aux_oe_n, 1'b1);
    chk("rst_wake", wake_n, 1'b1);
    chk("rst_faults", {lf_oe_n, af_oe_n}, 2'b11);
    reset <= 1'b0;
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, ADDR_CTRL, {27'h0, rows[i].ctrl});
      tx_data <= rows[i].tx;
      aux_in_pin <= rows[i].ain;
      mlev <= rows[i].ml;
      settle();
      chk("link_oe_n", link_oe_n, rows[i].loe);
      if (rows[i].loe == 1'b0) chk("link_o", link_o, rows[i].lo);
      chk("aux_oe_n", aux_oe_n, rows[i].aoe);
      if (rows[i].aoe == 1'b0) chk("aux_o", aux_o, rows[i].ao);
      chk("aux_in_level", aux_in_level, rows[i].ail);
      chk("rx_data", rx_data, rows[i].rx);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status_drv", rd[7:6], {~rows[i].aoe, ~rows[i].loe});
    end
    $display("pin table done");
    for (int c = 0; c < 4; c++) begin
      {cs1, cs0} <= c[1:0];
      settle();
      chk("limit_code", limit_code, c[1:0]);
      chk("limit_ma", limit_ma, lim[c]);
      apb(1'b0, ADDR_LIMIT, 32'h0);
      chk("limit_reg", rd, {23'h0, lim[c]});
    end
    apb(1'b1, ADDR_CTRL, 32'h00000015);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_read", rd, 32'h00000015);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_err", {er, rd}, {1'b1, 32'h0});
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF);
    chk("ro_write_err", er, 1'b0);
    $display("register test done");
    apb(1'b1, ADDR_CTRL, 32'h00000007);
    sense.aux_oc <= 1'b1;
    repeat (10) @(posedge clk);
    sense.aux_oc <= 1'b0;
    settle();
    chk("short_oc", af_oe_n, 1'b1);
    sense.aux_oc <= 1'b1;
    repeat (31) @(posedge clk);
    chk("aux_fault", {af_oe_n, af_o}, 2'b00);
    chk("aux_still_on", aux_oe_n, 1'b0);
    sense.aux_oc <= 1'b0;
    sense.link_th <= 1'b1;
    settle();
    chk("aux_fault_clr", af_oe_n, 1'b1);
    chk("link_th", {lf_oe_n, link_oe_n}, 2'b01);
    sense.link_th <= 1'b0;
    settle();
    chk("link_th_clr", {lf_oe_n, link_oe_n}, 2'b10);
    $display("fault test done");
    apb(1'b1, ADDR_CTRL, 32'h00000017);
    sense.link_oc <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (link_oe_n !== 1'b1 && n < 60);
    chk("retry_off", {lf_o, lf_oe_n, link_oe_n}, 3'b001);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (link_oe_n !== 1'b0 && n < 100);
    chk("retry_period", (n >= RETRY - 2 && n <= RETRY + 3), 1'b1);
    sense.link_oc <= 1'b0;
    repeat (RETRY + 11) @(posedge clk);
    chk("retry_end", {lf_oe_n, link_oe_n}, 2'b10);
    $display("retry test done");
    sense.wake_seen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wake_n !== 1'b0 && n < 20);
    n = 0;
    while (wake_n === 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk("wake_len", n, 32'd10);
    sense.wake_seen <= 1'b0;
    $display("wake test done");
    sense.warn_below <= 1'b1;
    settle();
    chk("warn", {wr_oe_n, wr_o, uv_oe_n}, 3'b001);
    sense.uv_below <= 1'b1;
    sense.uv_release <= 1'b0;
    aux_in_pin <= 1'b1;
    settle();
    chk("uvlo", {uv_oe_n, uv_o, link_oe_n}, 3'b001);
    chk("uv_aux_in", aux_in_level, 1'b0);
    sense.uv_below <= 1'b0;
    settle();
    chk("uv_hyst", uv_oe_n, 1'b0);
    sense.uv_release <= 1'b1;
    sense.warn_below <= 1'b0;
    settle();
    chk("uv_release", {uv_oe_n, wr_oe_n}, 2'b11);
    $display("supply test done");
    summarize();
  end
endmodule : tb

`default_nettype wire
